//--- design/dqirq_map.svh
// Register offsets, field positions and reset values for the interrupt block
`ifndef DQIRQ_MAP_SVH
`define DQIRQ_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define DQIRQ_STATUS_OFS   4'h0
`define DQIRQ_ENABLE_OFS   4'h4
`define DQIRQ_CTRL_OFS     4'h8
`define DQIRQ_LEVEL_OFS    4'hc

// ****************************************
// Source bit positions
// ****************************************
`define DQIRQ_BIT_ACQ_RUN    0
`define DQIRQ_BIT_ACQ_STOP   1
`define DQIRQ_BIT_ACQ_DONE   2
`define DQIRQ_BIT_ACQ_FIFO   3
`define DQIRQ_BIT_SAMPLE     4
`define DQIRQ_BIT_EOSCAN     5
`define DQIRQ_BIT_EOINTV     6
`define DQIRQ_BIT_OUT_RUN    7
`define DQIRQ_BIT_OUT_DONE   8
`define DQIRQ_BIT_OUT_FIFO   9
`define DQIRQ_BIT_TOP_CH     10
`define DQIRQ_BIT_WRAP       11
`define DQIRQ_BIT_EXT        12
`define DQIRQ_NSRC           13

// Control register: bit 0 selects falling edge on the external pin
`define DQIRQ_CTRL_FALL_BIT  0

// ****************************************
// Reset values
// ****************************************
`define DQIRQ_ENABLE_RST   13'h0000
`define DQIRQ_CTRL_RST     1'h0

`endif

//--- design/dqirq_pkg.sv
// Types shared by the interrupt block
package dqirq_pkg;

	// Register bus request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} dqirq_req_t;

	// Pulse and level sources from sequencers and FIFOs
	typedef struct packed {
		logic acq_run_active_irq;
		logic acq_stop_trigger_irq;
		logic acq_finished_irq;
		logic acq_fifo_quarter_irq;
		logic per_sample_irq;
		logic end_of_scan_irq;
		logic end_of_interval_irq;
		logic out_run_active_irq;
		logic out_finished_irq;
		logic out_fifo_quarter_irq;
		logic top_channel_irq;
		logic wave_wrap_irq;
	} dqirq_src_t;

endpackage

//--- design/dqirq_top.sv
// Interrupt source collection and host request for the acquisition board
`timescale 1ns/1ns
`include "dqirq_map.svh"

module dqirq_top
	import dqirq_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire dqirq_req_t  bus_req,
	output logic [31:0]      bus_rdata,
	input  wire dqirq_src_t  src,
	input  wire logic        ext_irq_pin,
	output logic             host_irq_n,
	output logic             irq
);

	// ****************************************
	// External pin synchroniser and edge detect
	// ****************************************
	logic [2:0]               ext_sync_q;
	logic                     ext_level_q;
	logic                     ext_level_d;
	logic                     ext_agree;
	logic                     ext_rise;
	logic                     ext_fall;
	logic                     ext_edge;
	logic                     fall_sel_q;

	// Three stages; stage 1 may be metastable, so only stage 2 reads it
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ext_sync_q <= 3'h0;
		else
			ext_sync_q <= {ext_sync_q[1:0], ext_irq_pin};
	end

	// A new pin level counts only once stages 2 and 3 agree on it
	assign ext_agree   = (ext_sync_q[1] == ext_sync_q[2]);
	assign ext_level_d = ext_agree ? ext_sync_q[2] : ext_level_q;
	assign ext_rise    = ext_level_d & ~ext_level_q;
	assign ext_fall    = ~ext_level_d & ext_level_q;

	// Filtered level resets low like an idle pin; a pin held high at reset
	// therefore shows up as one rising edge shortly after release
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			ext_level_q <= 1'b0;
		else
			ext_level_q <= ext_level_d;
	end

	// Only the selected direction raises the source; the other is dropped
	assign ext_edge = fall_sel_q ? ext_fall : ext_rise;

	// ****************************************
	// Source vector
	// ****************************************
	logic [`DQIRQ_NSRC-1:0]   set_vec;

	// Level sources set the flag every cycle they are high, so it stays up
	assign set_vec[`DQIRQ_BIT_ACQ_RUN]  = src.acq_run_active_irq;
	assign set_vec[`DQIRQ_BIT_ACQ_STOP] = src.acq_stop_trigger_irq;
	assign set_vec[`DQIRQ_BIT_ACQ_DONE] = src.acq_finished_irq;
	assign set_vec[`DQIRQ_BIT_ACQ_FIFO] = src.acq_fifo_quarter_irq;
	assign set_vec[`DQIRQ_BIT_SAMPLE]   = src.per_sample_irq;
	assign set_vec[`DQIRQ_BIT_EOSCAN]   = src.end_of_scan_irq;
	assign set_vec[`DQIRQ_BIT_EOINTV]   = src.end_of_interval_irq;
	assign set_vec[`DQIRQ_BIT_OUT_RUN]  = src.out_run_active_irq;
	assign set_vec[`DQIRQ_BIT_OUT_DONE] = src.out_finished_irq;
	assign set_vec[`DQIRQ_BIT_OUT_FIFO] = src.out_fifo_quarter_irq;
	assign set_vec[`DQIRQ_BIT_TOP_CH]   = src.top_channel_irq;
	assign set_vec[`DQIRQ_BIT_WRAP]     = src.wave_wrap_irq;
	assign set_vec[`DQIRQ_BIT_EXT]      = ext_edge;

	// ****************************************
	// Register decode
	// ****************************************
	logic                     sel_status;
	logic                     sel_enable;
	logic                     sel_ctrl;
	logic                     sel_level;
	logic                     ack_status;
	logic                     wr_enable;
	logic                     wr_ctrl;

	// Acknowledge is a read of the status register
	assign sel_status = (bus_req.addr == `DQIRQ_STATUS_OFS);
	assign sel_enable = (bus_req.addr == `DQIRQ_ENABLE_OFS);
	assign sel_ctrl   = (bus_req.addr == `DQIRQ_CTRL_OFS);
	assign sel_level  = (bus_req.addr == `DQIRQ_LEVEL_OFS);
	assign ack_status = bus_req.rd & sel_status;
	assign wr_enable  = bus_req.wr & sel_enable;
	assign wr_ctrl    = bus_req.wr & sel_ctrl;

	// ****************************************
	// Sticky flags, enables and control
	// ****************************************
	logic [`DQIRQ_NSRC-1:0]   flag_q;
	logic [`DQIRQ_NSRC-1:0]   flag_d;
	logic [`DQIRQ_NSRC-1:0]   enable_q;
	logic [`DQIRQ_NSRC-1:0]   live_q;

	// Per bit: set wins over the acknowledge so no event is lost
	genvar gi;
	generate
		for (gi = 0; gi < `DQIRQ_NSRC; gi++)
		begin : g_flag
			assign flag_d[gi] = set_vec[gi] | (flag_q[gi] & ~ack_status);
		end
	endgenerate

	// Flag and raw source snapshot registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag_q <= '0;
			live_q <= '0;
		end
		else
		begin
			flag_q <= flag_d;
			live_q <= set_vec;
		end
	end

	// Software enable and edge polarity
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_q   <= `DQIRQ_ENABLE_RST;
			fall_sel_q <= `DQIRQ_CTRL_RST;
		end
		else
		begin
			if (wr_enable)
				enable_q <= bus_req.wdata[`DQIRQ_NSRC-1:0];
			if (wr_ctrl)
				fall_sel_q <= bus_req.wdata[`DQIRQ_CTRL_FALL_BIT];
		end
	end

	// ****************************************
	// Request output
	// ****************************************
	logic                     irq_q;

	// Registered so the pin never glitches while flags settle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(flag_d & enable_q);
	end

	assign irq        = irq_q;
	assign host_irq_n = ~irq_q;

	// ****************************************
	// Read data
	// ****************************************
	logic [31:0]              rdata_q;
	logic [31:0]              rd_mux;

	// Unmapped addresses read as zero
	assign rd_mux = sel_status ? {19'h0, flag_q}
	              : sel_enable ? {19'h0, enable_q}
	              : sel_ctrl   ? {31'h0, fall_sel_q}
	              : sel_level  ? {19'h0, live_q}
	              : 32'h0;

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 32'h0;
		else
			rdata_q <= bus_req.rd ? rd_mux : 32'h0;
	end

	assign bus_rdata = rdata_q;

	// ****************************************
	// Checks
	// ****************************************
	// Status read with no new event on the watched bit
	sequence s_ack_no_set(int b);
		ack_status && !set_vec[b];
	endsequence

	// Filtered rising edge while rising edges are selected
	sequence s_ext_rise_sel;
		!fall_sel_q && ext_rise;
	endsequence

	// Filtered falling edge while falling edges are selected
	sequence s_ext_fall_sel;
		fall_sel_q && ext_fall;
	endsequence

	chk_req_follows_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
		|(flag_d & enable_q) |=> !host_irq_n)
		else $error("request not raised for enabled flag");

	chk_req_drops_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(|(flag_d & enable_q)) |=> host_irq_n)
		else $error("request raised with no enabled flag");

	chk_run_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.acq_run_active_irq |=> flag_q[`DQIRQ_BIT_ACQ_RUN])
		else $error("run flag not set");

	chk_stop_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.acq_stop_trigger_irq |=> flag_q[`DQIRQ_BIT_ACQ_STOP])
		else $error("stop flag not set");

	chk_done_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.acq_finished_irq |=> flag_q[`DQIRQ_BIT_ACQ_DONE])
		else $error("done flag not set");

	chk_wrap_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.wave_wrap_irq |=> flag_q[`DQIRQ_BIT_WRAP])
		else $error("wrap flag not set");

	// Selected rising edge latches the external flag
	chk_rise_edge_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ext_rise_sel |=> flag_q[`DQIRQ_BIT_EXT])
		else $error("rising edge not latched");

	// Rising edge in falling mode leaves a clear flag clear
	chk_fall_edge_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(fall_sel_q && ext_rise && !flag_q[`DQIRQ_BIT_EXT]) |=> !flag_q[`DQIRQ_BIT_EXT])
		else $error("rising edge taken in falling mode");

	// Selected falling edge latches the external flag
	chk_fall_edge_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ext_fall_sel |=> flag_q[`DQIRQ_BIT_EXT])
		else $error("falling edge not latched");

	// Falling edge in rising mode leaves a clear flag clear
	chk_rise_edge_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!fall_sel_q && ext_fall && !flag_q[`DQIRQ_BIT_EXT]) |=> !flag_q[`DQIRQ_BIT_EXT])
		else $error("falling edge taken in rising mode");

	// A filtered rising edge needs both late stages settled on the new level
	chk_edge_two_agree: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ext_rise |-> (ext_sync_q[1] && ext_sync_q[2]))
		else $error("edge taken before stages agree");

	chk_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(flag_q[`DQIRQ_BIT_ACQ_DONE] && !ack_status) |=> flag_q[`DQIRQ_BIT_ACQ_DONE])
		else $error("flag cleared without acknowledge");

	chk_ack_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_ack_no_set(`DQIRQ_BIT_ACQ_DONE) |=> !flag_q[`DQIRQ_BIT_ACQ_DONE])
		else $error("acknowledge did not clear flag");

	chk_ext_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ack_status && ext_edge) |=> flag_q[`DQIRQ_BIT_EXT])
		else $error("edge in acknowledge cycle lost");

	// With every source masked the line stays released
	chk_masked_no_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(enable_q == '0) |=> host_irq_n)
		else $error("request raised while all masked");

	// ****************************************
	// Checks: remaining sources
	// ****************************************

	// Input FIFO quarter event latches
	chk_fifo_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.acq_fifo_quarter_irq |=> flag_q[`DQIRQ_BIT_ACQ_FIFO])
		else $error("input fifo flag not set");

	// Conversion done event latches
	chk_sample_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.per_sample_irq |=> flag_q[`DQIRQ_BIT_SAMPLE])
		else $error("sample flag not set");

	// End of scan event latches
	chk_scan_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.end_of_scan_irq |=> flag_q[`DQIRQ_BIT_EOSCAN])
		else $error("scan flag not set");

	// End of interval event latches
	chk_intv_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.end_of_interval_irq |=> flag_q[`DQIRQ_BIT_EOINTV])
		else $error("interval flag not set");

	// Output running level latches
	chk_orun_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.out_run_active_irq |=> flag_q[`DQIRQ_BIT_OUT_RUN])
		else $error("output run flag not set");

	// Output sequence completion latches
	chk_odone_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.out_finished_irq |=> flag_q[`DQIRQ_BIT_OUT_DONE])
		else $error("output done flag not set");

	// Output FIFO quarter event latches
	chk_ofifo_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.out_fifo_quarter_irq |=> flag_q[`DQIRQ_BIT_OUT_FIFO])
		else $error("output fifo flag not set");

	// Top channel update latches
	chk_topch_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		src.top_channel_irq |=> flag_q[`DQIRQ_BIT_TOP_CH])
		else $error("top channel flag not set");

	// ****************************************
	// Checks: register bus
	// ****************************************

	// Status read returns the flags as they stood before the clear
	chk_status_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ack_status |=> (bus_rdata == {19'h0, $past(flag_q)}))
		else $error("status read data wrong");

	// Enable read returns the mask
	chk_enable_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(bus_req.rd && sel_enable) |=> (bus_rdata == {19'h0, $past(enable_q)}))
		else $error("enable read data wrong");

	// Control read returns the edge select
	chk_ctrl_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(bus_req.rd && sel_ctrl) |=> (bus_rdata == {31'h0, $past(fall_sel_q)}))
		else $error("control read data wrong");

	// Level read returns the raw sources of the cycle before
	chk_level_read_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(bus_req.rd && sel_level) |=> (bus_rdata == {19'h0, $past(live_q)}))
		else $error("level read data wrong");

	// Unmapped reads give zero
	chk_unmapped_read_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(bus_req.rd && !(sel_status || sel_enable || sel_ctrl || sel_level))
		|=> (bus_rdata == 32'h0))
		else $error("unmapped read not zero");

	// Read data stand one cycle only, zero otherwise
	chk_rdata_idle_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!bus_req.rd |=> (bus_rdata == 32'h0))
		else $error("read data outside read cycle");

	// Enable write lands at the next edge
	chk_enable_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_enable |=> (enable_q == $past(bus_req.wdata[`DQIRQ_NSRC-1:0])))
		else $error("enable write lost");

	// Control write lands at the next edge
	chk_ctrl_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ctrl |=> (fall_sel_q == $past(bus_req.wdata[`DQIRQ_CTRL_FALL_BIT])))
		else $error("control write lost");

endmodule // dqirq_top

//--- test/dqirq_host_model.sv
// Host side model of the interrupt path: counts requests on the active-low line
`timescale 1ns/1ns

module dqirq_host_model
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       host_irq_n,
	output logic [7:0]      req_count
);
	// ****************************************
	// Request counter
	// ****************************************
	logic level_q;

	// Level-sensitive host: a new request is a low after a high, never a glitch count
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			level_q   <= 1'b0;
			req_count <= 8'h00;
		end
		else
		begin
			level_q <= !host_irq_n;
			if (!host_irq_n && !level_q)
				req_count <= req_count + 8'h01;
		end
	end
endmodule // dqirq_host_model

//--- test/tb.sv
// Self-checking bench for the interrupt source block
`timescale 1ns/1ns
`include "dqirq_map.svh"

module tb
	import dqirq_pkg::*;
;
	logic        clk_sys;
	logic        rst_n;
	dqirq_req_t  req;
	logic [31:0] bus_rdata;
	dqirq_src_t  src;
	logic        ext_irq_pin;
	logic        host_irq_n;
	logic        irq;
	logic [7:0]  req_count;
	int          n_errors;
	int          checked;
	int          cycles;

	dqirq_top dqirq_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(req),
		.bus_rdata(bus_rdata), .src(src), .ext_irq_pin(ext_irq_pin),
		.host_irq_n(host_irq_n), .irq(irq));
	dqirq_host_model dqirq_host_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.host_irq_n(host_irq_n), .req_count(req_count));

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic chk_irq(input logic e);
		chk("irq", {31'h0, e}, {31'h0, irq});
		chk("host_irq_n", {31'h0, !e}, {31'h0, host_irq_n});
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		chk("rdata", e, bus_rdata);
	endtask

	task automatic pulse(input logic [11:0] s);
		@(posedge clk_sys);
		src <= s;
		@(posedge clk_sys);
		src <= '0;
		#1;
	endtask

	task automatic print_verdict();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			print_verdict();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial
	begin
		rst_n = 1'b0;
		req = '0;
		src = '0;
		ext_irq_pin = 1'b0;
		n_errors = 0;
		checked = 0;
		cycles = 0;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		#1;
		chk_irq(1'b0);
		rd(`DQIRQ_ENABLE_OFS, 32'h0);
		rd(`DQIRQ_CTRL_OFS, 32'h0);
		rd(4'h2, 32'h0);
		wr(`DQIRQ_ENABLE_OFS, 32'hffffffff);
		rd(`DQIRQ_ENABLE_OFS, 32'h1fff);
		$display("test reset and access done");
		// Source i sits at struct bit 11-i and at status bit i
		for (int i = 0; i < 12; i++)
		begin
			pulse(12'h001 << (11 - i));
			chk_irq(1'b1);
			rd(`DQIRQ_STATUS_OFS, 32'h1 << i);
			rd(`DQIRQ_STATUS_OFS, 32'h0);
			chk_irq(1'b0);
		end
		chk("req_count", 32'd12, {24'h0, req_count});
		$display("test each source done");
		wr(`DQIRQ_ENABLE_OFS, 32'h0);
		pulse(12'h200);
		chk_irq(1'b0);
		rd(`DQIRQ_STATUS_OFS, 32'h4);
		// Held run level shows in the raw level register, then stays latched
		@(posedge clk_sys);
		src <= 12'h800;
		rd(`DQIRQ_LEVEL_OFS, 32'h1);
		@(posedge clk_sys);
		src <= '0;
		rd(`DQIRQ_STATUS_OFS, 32'h1);
		// New event in the read-clear cycle must stay pending
		@(posedge clk_sys);
		req.addr <= `DQIRQ_STATUS_OFS;
		req.rd   <= 1'b1;
		src      <= 12'h001;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		src    <= '0;
		#1;
		chk("rdata", 32'h0, bus_rdata);
		rd(`DQIRQ_STATUS_OFS, 32'h800);
		$display("test mask and set-wins done");
		wr(`DQIRQ_ENABLE_OFS, 32'h1000);
		ext_irq_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		#1;
		chk_irq(1'b1);
		rd(`DQIRQ_STATUS_OFS, 32'h1000);
		@(posedge clk_sys);
		ext_irq_pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(`DQIRQ_STATUS_OFS, 32'h0);
		wr(`DQIRQ_CTRL_OFS, 32'h1);
		ext_irq_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		rd(`DQIRQ_STATUS_OFS, 32'h0);
		@(posedge clk_sys);
		ext_irq_pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(`DQIRQ_STATUS_OFS, 32'h1000);
		// Edge lands in the very cycle of a status read: it must stay pending
		wr(`DQIRQ_CTRL_OFS, 32'h0);
		ext_irq_pin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		req.addr <= `DQIRQ_STATUS_OFS;
		req.rd   <= 1'b1;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1;
		chk("rdata", 32'h0, bus_rdata);
		chk_irq(1'b1);
		rd(`DQIRQ_STATUS_OFS, 32'h1000);
		chk_irq(1'b0);
		$display("test external edge done");
		print_verdict();
	end
endmodule // tb
